/* rtl/ldc_ctrl.sv */
// APB register group: write locks, nonvolatile controls, fault masks, starts
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module ldc_ctrl #(
    parameter int ADDR_W = 10          // Byte address width
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic              reference_fault,
    input  wire logic              checksum_fault,
    input  wire logic              short_fault,
    input  wire logic              open_fault,
    input  wire logic              overtemp_fault,
    input  wire logic              conv_complete,
    input  wire logic [7:0]        conv_result,
    input  wire logic              burn_finished,
    output logic                   err_out,
    output logic                   err_oe,
    output logic                   overtemp_shutdown,
    output logic                   setting_wr_allow,
    output logic                   current_wr_allow,
    output logic                   duty_wr_allow,
    output logic                   hold_nvm_state,
    output logic                   nvm_reload_trigger,
    output logic [4:0]             converter_channel_sel,
    output logic                   conv_start,
    output logic                   pwm_clock_source_sel,
    output logic                   common_duty_enable,
    output logic                   nvm_readback_source_sel,
    output logic                   nvm_program_state_enable,
    output logic                   nvm_burn_start,
    output logic                   single_short_diag_start,
    output logic                   hidden_diag_start,
    output logic [5:0]             clear_cmd,
    output logic [7:0]             eeprom_gate_key
);

    // Byte addresses of the mapped words
    localparam logic [ADDR_W-1:0] A_CLEAR  = ADDR_W'({ldc_pkg::IDX_CLEAR, 2'b00});
    localparam logic [ADDR_W-1:0] A_LOCK   = ADDR_W'({ldc_pkg::IDX_LOCK, 2'b00});
    localparam logic [ADDR_W-1:0] A_MISC6  = ADDR_W'({ldc_pkg::IDX_MISC6, 2'b00});
    localparam logic [ADDR_W-1:0] A_MISC7  = ADDR_W'({ldc_pkg::IDX_MISC7, 2'b00});
    localparam logic [ADDR_W-1:0] A_MASK   = ADDR_W'({ldc_pkg::IDX_MASK, 2'b00});
    localparam logic [ADDR_W-1:0] A_GATE   = ADDR_W'({ldc_pkg::IDX_GATE, 2'b00});
    localparam logic [ADDR_W-1:0] A_FLAGS  = ADDR_W'({ldc_pkg::IDX_FLAGS, 2'b00});
    localparam logic [ADDR_W-1:0] A_RESULT = ADDR_W'({ldc_pkg::IDX_RESULT, 2'b00});

    // Whole state of the block
    typedef struct packed {
        logic [3:0]  lock;        // Write guards, clear/conf/current/duty
        logic        hold;        // Stay in nonvolatile state
        logic        reload;      // One-cycle reload pulse
        logic [4:0]  chan;        // Converter channel
        logic        conv_go;     // One-cycle conversion start
        logic        clk_sel;     // PWM clock source
        logic        share;       // Common duty
        logic        rb_src;      // Readback source
        logic        prog;        // Programming state
        logic [4:0]  fmask;       // Fault masks, ref..overtemp
        logic        burn;        // One-cycle burn start
        logic        ssd;         // One-cycle short diagnostic start
        logic        hid;         // One-cycle hidden diagnostic start
        logic [7:0]  gate;        // Gate key
        logic        conv_flag;   // Conversion done
        logic        burn_flag;   // Burn complete
        logic [5:0]  clr;         // One-cycle clear commands
        logic        err;         // Error pin drive
        logic        ot_sd;       // Overtemp shutdown
        logic [31:0] rdata;       // Read data
    } ldc_state_t;

    ldc_state_t st;               // Registered state
    ldc_state_t next_st;          // Next state

    logic       setup;            // APB setup phase
    logic       access;           // APB access phase, completes now
    logic       wr;               // Completing write with low lane
    logic       mapped;           // Address decodes
    logic       conf_ok;          // Config registers writable
    logic [7:0] wd;               // Low byte of write data
    logic [7:0] rd;               // Read value for decode

    // Bus phase decode
    always_comb begin
        setup   = psel && !penable;
        access  = psel && penable;
        wr      = access && pwrite && pstrb[0];
        wd      = pwdata[7:0];
        conf_ok = !st.lock[ldc_pkg::LK_CONF];   // [R2]
        mapped  = (paddr == A_CLEAR) || (paddr == A_LOCK) ||
                  (paddr == A_MISC6) || (paddr == A_MISC7) ||
                  (paddr == A_MASK) || (paddr == A_GATE) ||
                  (paddr == A_FLAGS) || (paddr == A_RESULT);
    end

    // Read multiplexer; unused bits stay zero
    always_comb begin
        rd = 8'h00;                                          // [R21]
        unique case (paddr)
            A_CLEAR:  rd = {2'b00, st.clr};
            A_LOCK:   rd = {4'h0, st.lock};
            A_MISC6:  rd = {st.hold, st.reload, 1'b0, st.chan};
            A_MISC7:  rd = {2'b00, st.clk_sel, st.share, 2'b00, st.rb_src, st.prog};
            A_MASK:   rd = {st.fmask, st.burn, st.ssd, st.hid};
            A_GATE:   rd = st.gate;
            A_FLAGS:  rd = {3'b000, st.burn_flag, 1'b0, st.conv_flag, 2'b00};
            A_RESULT: rd = conv_result;
            default:  rd = 8'h00;
        endcase
    end

    // Next-state logic
    always_comb begin
        next_st = st;
        // Pulses last one cycle
        next_st.reload  = 1'b0;                              // [R6]
        next_st.conv_go = 1'b0;
        next_st.burn    = 1'b0;                              // [R15]
        next_st.ssd     = 1'b0;                              // [R16]
        next_st.hid     = 1'b0;                              // [R17]
        next_st.clr     = '0;
        // Read data captured in setup so prdata is a flop
        if (setup) begin
            next_st.rdata = {24'h000000, rd};
        end
        if (wr) begin
            unique case (paddr)
                A_LOCK: begin
                    next_st.lock = wd[3:0];                  // [R21]
                end
                A_CLEAR: begin
                    // Locked write is dropped whole
                    if (!st.lock[ldc_pkg::LK_CLEAR]) begin   // [R1] [R20]
                        next_st.clr = wd[ldc_pkg::CLR_W-1:0];
                    end
                end
                A_MISC6: begin
                    if (conf_ok) begin                       // [R2] [R20]
                        next_st.hold    = wd[ldc_pkg::M6_HOLD];  // [R5]
                        next_st.reload  = wd[ldc_pkg::M6_RELOAD]; // [R6]
                        next_st.chan    = wd[ldc_pkg::CH_W-1:0];
                        next_st.conv_go = 1'b1;              // [R7]
                    end
                end
                A_MISC7: begin
                    if (conf_ok) begin                       // [R2]
                        next_st.clk_sel = wd[ldc_pkg::M7_CLKSEL]; // [R8]
                        next_st.share   = wd[ldc_pkg::M7_SHARE];  // [R9]
                        next_st.rb_src  = wd[ldc_pkg::M7_RBSRC];  // [R10]
                        next_st.prog    = wd[ldc_pkg::M7_PROG];   // [R11]
                    end
                end
                A_MASK: begin
                    if (conf_ok) begin                       // [R2]
                        next_st.fmask = wd[ldc_pkg::MK_REF:ldc_pkg::MK_OT]; // [R12] [R13]
                        // Burning only honoured in programming state
                        next_st.burn  = wd[ldc_pkg::MK_BURN] && st.prog; // [R15]
                        next_st.ssd   = wd[ldc_pkg::MK_SSD];    // [R16]
                        next_st.hid   = wd[ldc_pkg::MK_HID];    // [R17]
                    end
                end
                A_GATE: begin
                    if (conf_ok) begin                       // [R2]
                        next_st.gate = wd;
                    end
                end
                default: begin
                    next_st.lock = st.lock;
                end
            endcase
        end
        // Result read clears done flag; a new completion wins
        if (access && !pwrite && paddr == A_RESULT) begin
            next_st.conv_flag = 1'b0;                        // [R18]
        end
        if (conv_complete) begin
            next_st.conv_flag = 1'b1;                        // [R18]
        end
        // New burn clears complete flag; completion wins
        if (next_st.burn) begin
            next_st.burn_flag = 1'b0;                        // [R19]
        end
        if (burn_finished) begin
            next_st.burn_flag = 1'b1;                        // [R19]
        end
        // Masked faults stay off the error pin
        next_st.err = (reference_fault && !st.fmask[ldc_pkg::MK_REF - ldc_pkg::MK_OT]) ||
                      (checksum_fault && !st.fmask[ldc_pkg::MK_CRC - ldc_pkg::MK_OT]) ||
                      (short_fault && !st.fmask[ldc_pkg::MK_SHORT - ldc_pkg::MK_OT]) ||
                      (open_fault && !st.fmask[ldc_pkg::MK_OPEN - ldc_pkg::MK_OT]) ||
                      (overtemp_fault && !st.fmask[ldc_pkg::MK_OT - ldc_pkg::MK_OT]); // [R14]
        // Shutdown ignores the mask
        next_st.ot_sd = overtemp_fault;                      // [R14]
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st      <= '0;
            st.lock <= ldc_pkg::LOCK_RST;                    // [R2] [R3] [R4]
        end else begin
            st <= next_st;
        end
    end

    // Outputs; zero-wait slave, unmapped gives an error
    always_comb begin
        pready                   = 1'b1;
        pslverr                  = access && !mapped;
        prdata                   = st.rdata;
        err_out                  = 1'b0;
        err_oe                   = st.err;
        overtemp_shutdown        = st.ot_sd;
        setting_wr_allow         = !st.lock[ldc_pkg::LK_CONF];  // [R2]
        current_wr_allow         = !st.lock[ldc_pkg::LK_CUR];   // [R3]
        duty_wr_allow            = !st.lock[ldc_pkg::LK_DUTY];  // [R4]
        hold_nvm_state           = st.hold;
        nvm_reload_trigger       = st.reload;
        converter_channel_sel    = st.chan;
        conv_start               = st.conv_go;
        pwm_clock_source_sel     = st.clk_sel;
        common_duty_enable       = st.share;
        nvm_readback_source_sel  = st.rb_src;
        nvm_program_state_enable = st.prog;
        nvm_burn_start           = st.burn;
        single_short_diag_start  = st.ssd;
        hidden_diag_start        = st.hid;
        clear_cmd                = st.clr;
        eeprom_gate_key          = st.gate;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Locked clear register takes no command
    clr_lock_block_a: assert property (              // [R1]
        wr && paddr == A_CLEAR && st.lock[3] |=> clear_cmd == 6'h00)
        else $error("clear command passed a set lock");
    // Locked config write leaves fields alone
    write_protect_ctrl_keep_a: assert property (              // [R2]
        wr && paddr == A_MISC7 && st.lock[2] |=> $stable(pwm_clock_source_sel)
            && $stable(nvm_program_state_enable) && $stable(common_duty_enable))
        else $error("locked config register changed");
    // Guards come up set after reset
    lock_reset_set_a: assert property (              // [R3]
        @(posedge clk) disable iff (1'b0) $past(srst) |-> !current_wr_allow
            && !duty_wr_allow && !setting_wr_allow)
        else $error("lock not set after reset");
    // Clearing the duty guard opens duty writes
    duty_unlock_a: assert property (                 // [R4]
        wr && paddr == A_LOCK && !pwdata[0] |=> duty_wr_allow)
        else $error("duty guard did not release");
    // Reload lasts one cycle
    reload_pulse_a: assert property (                // [R6]
        nvm_reload_trigger |=> !nvm_reload_trigger)
        else $error("reload pulse too long");
    // Channel write starts conversion on that channel
    conv_start_chan_a: assert property (             // [R7]
        wr && paddr == A_MISC6 && !st.lock[2] |=> conv_start
            && converter_channel_sel == $past(pwdata[4:0]))
        else $error("conversion not started on write");
    // Burn only from programming state
    burn_gate_a: assert property (                   // [R15]
        nvm_burn_start |-> $past(nvm_program_state_enable))
        else $error("burn outside programming state");
    // Completion raises done flag; no result read in between to clear it
    conv_flag_set_a: assert property (               // [R18]
        conv_complete ##1 !(access && !pwrite && paddr == A_RESULT)
            ##1 (setup && paddr == A_FLAGS) |=> prdata[ldc_pkg::FL_CONV])
        else $error("done flag not set");
    // Unmasked reference fault drives error pin
    ref_err_a: assert property (                     // [R12]
        reference_fault && !st.fmask[4] |=> err_oe)
        else $error("reference fault not reported");
    // Shutdown follows overtemp despite mask
    ot_shutdown_a: assert property (                 // [R14]
        overtemp_fault ##1 1'b1 |-> overtemp_shutdown)
        else $error("overtemp did not shut down");

    burn_cov_c: cover property (nvm_burn_start ##[1:20] burn_finished);
    conv_cov_c: cover property (conv_start ##[1:20] conv_complete);
    lock_cov_c: cover property (wr && paddr == A_CLEAR && st.lock[3]);

endmodule

/* rtl/ldc_pkg.sv */
// Constants for the LED driver lock and misc control register group
// How it works
// R1 - Clear lock bit blocks clear register writes
// R2 - Config lock resets set, protects config registers
// R3 - Current lock resets set, protects current settings
// R4 - Duty lock resets set, protects duty registers
// R5 - Bit seven holds nonvolatile state, resets zero
// R6 - Reload bit copies memory, then self clears
// R7 - Channel field write starts a conversion
// R8 - Bit five picks internal or external PWM clock
// R9 - Shared duty bit makes channels follow first
// R10 - Bit one picks array or shadow readback
// R11 - Bit zero enables programming state, resets zero
// R12 - Reference and checksum masks gate error output
// R13 - Short and open masks gate error output
// R14 - Overtemp mask hides error, shutdown still happens
// R15 - Burn start works only in programming state
// R16 - Short diagnostic start bit self clears
// R17 - Hidden diagnostic start bit self clears
// R18 - Conversion done flag, cleared by result read
// R19 - Burn complete flag set when burning ends
// R20 - Locked write changes nothing anywhere
// R21 - Reserved bits read zero, ignore writes
package ldc_pkg;
    // Register indices; byte address is index times four
    localparam logic [7:0] IDX_CLEAR  = 8'h60;
    localparam logic [7:0] IDX_LOCK   = 8'h61;
    localparam logic [7:0] IDX_MISC6  = 8'h62;
    localparam logic [7:0] IDX_MISC7  = 8'h63;
    localparam logic [7:0] IDX_MASK   = 8'h64;
    localparam logic [7:0] IDX_GATE   = 8'h65;
    localparam logic [7:0] IDX_FLAGS  = 8'h71;
    localparam logic [7:0] IDX_RESULT = 8'h73;
    // Lock field positions
    localparam int LK_CLEAR = 3;
    localparam int LK_CONF  = 2;
    localparam int LK_CUR   = 1;
    localparam int LK_DUTY  = 0;
    localparam logic [3:0] LOCK_RST = 4'hF;
    // Control register fields
    localparam int M6_HOLD   = 7;
    localparam int M6_RELOAD = 6;
    localparam int M7_CLKSEL = 5;
    localparam int M7_SHARE  = 4;
    localparam int M7_RBSRC  = 1;
    localparam int M7_PROG   = 0;
    localparam int MK_REF    = 7;
    localparam int MK_CRC    = 6;
    localparam int MK_SHORT  = 5;
    localparam int MK_OPEN   = 4;
    localparam int MK_OT     = 3;
    localparam int MK_BURN   = 2;
    localparam int MK_SSD    = 1;
    localparam int MK_HID    = 0;
    localparam int FL_BURN   = 4;
    localparam int FL_CONV   = 2;
    localparam int CH_W      = 5;
    localparam int CLR_W     = 6;
endpackage

/* sim/ldc_host_model.sv */
// APB host model standing in for the controlling microcontroller
`timescale 1ns/1ps
module ldc_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata
);
    // Idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 10'h3FF;
        pwdata  = 32'hFFFFFFFF;
        pstrb   = 4'h0;
    end

    // One transfer: setup, then access held until pready is seen high or 16 wait cycles pass
    task automatic xfer(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
                        input logic [3:0] strb, output logic [31:0] rdata,
                        output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        pstrb   <= strb;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Bounded wait; a hung slave is reported, never waited on forever
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        rdata = prdata;
        err   = pslverr;
        hung  = (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines show junk so a stale value never looks valid
        paddr   <= ~addr;
        pwdata  <= ~wdata;
    endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the lock and misc control register group
`timescale 1ns/1ps
module testbench;
    // Bus and control wires
    logic        clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  pstrb;
    logic        reference_fault, checksum_fault, short_fault, open_fault, overtemp_fault;
    logic        conv_complete, burn_finished, errv;
    logic [7:0]  conv_result, eeprom_gate_key;
    logic        err_out, err_oe, overtemp_shutdown, setting_wr_allow, current_wr_allow;
    logic        duty_wr_allow, hold_nvm_state, nvm_reload_trigger, conv_start;
    logic        pwm_clock_source_sel, common_duty_enable, nvm_readback_source_sel;
    logic        nvm_program_state_enable, nvm_burn_start, single_short_diag_start;
    logic        hidden_diag_start;
    logic [4:0]  converter_channel_sel;
    logic [5:0]  clear_cmd, clear_acc;
    logic [7:0]  regs [8];
    // Reference model state, expected and seen pulse counts
    int m_lock, m_m6, m_m7, m_mk, m_gate, m_flags, m_res, exp_clr, d;
    int exp_conv, exp_reload, exp_burn, exp_ssd, exp_hid;
    int n_conv, n_reload, n_burn, n_ssd, n_hid, num_errors, checks, seed;

    ldc_ctrl #(.ADDR_W(10)) ldc_ctrl_inst (
        .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .pslverr, .prdata, .reference_fault, .checksum_fault, .short_fault, .open_fault,
        .overtemp_fault, .conv_complete, .conv_result, .burn_finished, .err_out, .err_oe,
        .overtemp_shutdown, .setting_wr_allow, .current_wr_allow, .duty_wr_allow,
        .hold_nvm_state, .nvm_reload_trigger, .converter_channel_sel, .conv_start,
        .pwm_clock_source_sel, .common_duty_enable, .nvm_readback_source_sel,
        .nvm_program_state_enable, .nvm_burn_start, .single_short_diag_start,
        .hidden_diag_start, .clear_cmd, .eeprom_gate_key
    );
    ldc_host_model ldc_host_model_inst (
        .clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata
    );

    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Pulse counters, sampled like a flop would see them
    always @(posedge clk) begin
        if (srst) begin
            clear_acc <= 6'h00;
        end else begin
            n_conv    <= n_conv + conv_start;
            n_reload  <= n_reload + nvm_reload_trigger;
            n_burn    <= n_burn + nvm_burn_start;
            n_ssd     <= n_ssd + single_short_diag_start;
            n_hid     <= n_hid + hidden_diag_start;
            clear_acc <= clear_acc | clear_cmd;
        end
    end

    // Verdict and end of run; the only exit
    task automatic complete_run();
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus access by register index; a hang ends the run
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [3:0] strb, output logic [31:0] rd, output logic err);
        logic hung;
        ldc_host_model_inst.xfer(wr, {idx, 2'b00}, wd, strb, rd, err, hung);
        if (hung) begin
            num_errors++;
            complete_run();
        end
    endtask

    // Model of a write as the register group should take it
    function automatic void model_write(input logic [7:0] idx, input int v);
        case (idx)
            ldc_pkg::IDX_LOCK: m_lock = v & 8'h0F;
            ldc_pkg::IDX_CLEAR: if (!m_lock[3]) exp_clr |= v & 8'h3F;
            ldc_pkg::IDX_MISC6: if (!m_lock[2]) begin
                m_m6 = v & 8'h9F;
                exp_conv++;
                exp_reload += v[6];
            end
            ldc_pkg::IDX_MISC7: if (!m_lock[2]) m_m7 = v & 8'h33;
            ldc_pkg::IDX_MASK: if (!m_lock[2]) begin
                m_mk = v & 8'hF8;
                exp_ssd += v[1];
                exp_hid += v[0];
                // Burn only counts while in programming state
                if (v[2] && m_m7[0]) begin
                    exp_burn++;
                    m_flags[4] = 0;
                end
            end
            ldc_pkg::IDX_GATE: if (!m_lock[2]) m_gate = v & 8'hFF;
            default: ;
        endcase
    endfunction

    // Expected read value per index
    function automatic int model_read(input logic [7:0] idx);
        case (idx)
            ldc_pkg::IDX_LOCK: return m_lock;
            ldc_pkg::IDX_MISC6: return m_m6;
            ldc_pkg::IDX_MISC7: return m_m7;
            ldc_pkg::IDX_MASK: return m_mk;
            ldc_pkg::IDX_GATE: return m_gate;
            ldc_pkg::IDX_FLAGS: return m_flags;
            ldc_pkg::IDX_RESULT: return m_res;
            default: return 0;
        endcase
    endfunction

    task automatic wr_do(input logic [7:0] idx, input int v);
        bus(1'b1, idx, v, 4'hF, rdv, errv);
        check(errv, 1'b0);
        model_write(idx, v);
    endtask

    task automatic rd_chk(input logic [7:0] idx);
        bus(1'b0, idx, 32'h0, 4'h0, rdv, errv);
        check(rdv, model_read(idx));
        check(errv, 1'b0);
        // Reading the result clears the done flag
        if (idx == ldc_pkg::IDX_RESULT) m_flags[2] = 0;
    endtask

    // Let pulses land, then compare the level outputs and counts
    task automatic settle_chk();
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(setting_wr_allow, !m_lock[2]);
        check(current_wr_allow, !m_lock[1]);
        check(duty_wr_allow, !m_lock[0]);
        check(hold_nvm_state, m_m6[7]);
        check(n_reload, exp_reload);
        check(converter_channel_sel, m_m6[4:0]);
        check(n_conv, exp_conv);
        check(pwm_clock_source_sel, m_m7[5]);
        check(common_duty_enable, m_m7[4]);
        check(nvm_readback_source_sel, m_m7[1]);
        check(nvm_program_state_enable, m_m7[0]);
        check(n_burn, exp_burn);
        check(n_ssd, exp_ssd);
        check(n_hid, exp_hid);
        check(clear_acc, exp_clr);
        check(eeprom_gate_key, m_gate[7:0]);
    endtask

    // Watchdog against a hang anywhere
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        seed = 32'h9E6A;
        regs = '{ldc_pkg::IDX_CLEAR, ldc_pkg::IDX_LOCK, ldc_pkg::IDX_MISC6, ldc_pkg::IDX_MISC7,
                 ldc_pkg::IDX_MASK, ldc_pkg::IDX_GATE, ldc_pkg::IDX_FLAGS, ldc_pkg::IDX_RESULT};
        srst = 1'b1;
        {reference_fault, checksum_fault, short_fault, open_fault, overtemp_fault} = 5'h00;
        {conv_complete, burn_finished} = 2'b00;
        conv_result = 8'h00;
        m_lock = 8'h0F;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // Reset values, then all-ones writes; the lock write keeps every guard set, the rest are refused
        for (int i = 0; i < 8; i++) rd_chk(regs[i]);
        settle_chk();
        for (int i = 0; i < 8; i++) wr_do(regs[i], 32'hFF);
        for (int i = 0; i < 8; i++) rd_chk(regs[i]);
        settle_chk();
        // Lock patterns; clear writes land only with bit 3 low
        for (int v = 0; v < 16; v += 5) begin
            wr_do(ldc_pkg::IDX_LOCK, v | 8'hF0);
            wr_do(ldc_pkg::IDX_CLEAR, 1 << (v / 5));
            rd_chk(ldc_pkg::IDX_LOCK);
            settle_chk();
        end
        wr_do(ldc_pkg::IDX_LOCK, 0);
        // Random control contents with start bits and reserved bits
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr_do(ldc_pkg::IDX_MISC6, d);
            wr_do(ldc_pkg::IDX_MISC7, d >> 8);
            wr_do(ldc_pkg::IDX_MASK, d >> 16);
            wr_do(ldc_pkg::IDX_GATE, d >> 24);
            settle_chk();
            for (int j = 1; j < 6; j++) rd_chk(regs[j]);
        end
        // Strobe-less write and an unmapped address
        bus(1'b1, ldc_pkg::IDX_GATE, ~m_gate, 4'h0, rdv, errv);
        rd_chk(ldc_pkg::IDX_GATE);
        bus(1'b0, 8'h7F, 32'h0, 4'h0, rdv, errv);
        check(errv, 1'b1);
        check(rdv, 32'h0);
        // Fault masking onto the error pin
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr_do(ldc_pkg::IDX_MASK, d & 8'hF8);
            @(posedge clk);
            {reference_fault, checksum_fault, short_fault, open_fault, overtemp_fault} <= d[12:8];
            settle_chk();
            check(err_oe, |(d[12:8] & ~m_mk[7:3]));
            check(overtemp_shutdown, d[8]);
            check(err_out, 1'b0);
        end
        // Conversion done flag, cleared by the result read
        d = $random(seed);
        @(posedge clk);
        conv_result <= d[7:0];
        conv_complete <= 1'b1;
        @(posedge clk);
        conv_complete <= 1'b0;
        m_flags[2] = 1;
        m_res = d & 8'hFF;
        rd_chk(ldc_pkg::IDX_FLAGS);
        rd_chk(ldc_pkg::IDX_RESULT);
        rd_chk(ldc_pkg::IDX_FLAGS);
        // Burn start refused outside, taken inside programming state
        wr_do(ldc_pkg::IDX_MISC7, 0);
        wr_do(ldc_pkg::IDX_MASK, 4);
        wr_do(ldc_pkg::IDX_MISC7, 1);
        wr_do(ldc_pkg::IDX_MASK, 4);
        settle_chk();
        rd_chk(ldc_pkg::IDX_FLAGS);
        @(posedge clk);
        burn_finished <= 1'b1;
        @(posedge clk);
        burn_finished <= 1'b0;
        m_flags[4] = 1;
        rd_chk(ldc_pkg::IDX_FLAGS);
        rd_chk(ldc_pkg::IDX_MASK);
        complete_run();
    end
endmodule
